// *** pkg/dts_pkg.sv ***
// Shared constants and types for the dual temperature sensor readout.
// Assumes a 40 MHz core clock and an SMBus host that owns the serial clock.
package dts_pkg;
	// Core clock rate and conversion period
	localparam int         CLK_HZ      = 40_000_000;
	localparam int         CONV_MS     = 125;
	// Bus addresses; the slave base is arbitrary, straps fill bits 1:0
	localparam logic [6:0] ARA_ADDR    = 7'h0C;
	localparam logic [6:0] SLAVE_BASE  = 7'h18;
	// Command codes
	localparam logic [7:0] CMD_LOC     = 8'h00;
	localparam logic [7:0] CMD_REM     = 8'h01;
	localparam logic [7:0] CMD_STATUS  = 8'h02;
	localparam logic [7:0] CMD_RCFG    = 8'h03;
	localparam logic [7:0] CMD_RRATE   = 8'h04;
	localparam logic [7:0] CMD_RLIM    = 8'h05;
	localparam logic [7:0] CMD_RLIM_LT = 8'h08;
	localparam logic [7:0] CMD_WCFG    = 8'h09;
	localparam logic [7:0] CMD_WRATE   = 8'h0A;
	localparam logic [7:0] CMD_WLIM    = 8'h0B;
	localparam logic [7:0] CMD_ONESHOT = 8'h0F;
	// Values after reset and fixed codes
	localparam logic [7:0] HIGH_POR    = 8'h7F;
	localparam logic [7:0] LOW_POR     = 8'hC9;
	localparam logic [7:0] RATE_POR    = 8'h02;
	localparam logic [1:0] CFG_POR     = 2'h0;
	localparam logic [7:0] TEMP_POR    = 8'h00;
	localparam logic [7:0] TEMP_MAX    = 8'h7F;
	localparam logic [7:0] TEMP_MIN    = 8'hBF;
	localparam logic [7:0] TEMP_ZERO   = 8'h00;
	// Configuration field positions within the stored pair
	localparam int         CFG_MASK    = 1;
	localparam int         CFG_STANDBY_PIN_N    = 0;
	// Flag positions; the flags sit in status bits 6:2
	localparam int         FL_OPEN     = 0;
	localparam int         FL_RLOW     = 1;
	localparam int         FL_RHIGH    = 2;
	localparam int         FL_LLOW     = 3;
	localparam int         FL_LHIGH    = 4;
	// Events handed from the link to the core
	typedef enum logic [1:0] {EV_CMD, EV_WR, EV_RD, EV_ARA} dts_evt_e;
	typedef struct packed {
		dts_evt_e   kind;
		logic [7:0] cmd;
		logic [7:0] data;
	} dts_evt_s;
endpackage : dts_pkg

// *** rtl/dts_smb_link.sv ***
// SMBus slave byte engine, running on the host's serial clock.
// Assumes the core inputs stay stable for several serial clock periods.
module dts_smb_link
	import dts_pkg::*;
(
	// Link clock and reset
	input  wire logic       smb_clk,
	input  wire logic       resetn,
	// Serial data pin
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Core side, quasi-static values and an event toggle
	input  wire logic [6:0] own_addr,
	input  wire logic [7:0] rd_byte,
	input  wire logic       alert_lvl,
	output logic            evt_tgl,
	output dts_evt_s        evt
);
	typedef enum {LK_IDLE, LK_ADDR, LK_ACK, LK_CMD, LK_DATA, LK_TX, LK_TXACK} dts_lk_e;

	dts_lk_e    st_q, nxt_q;
	logic [2:0] cnt_q;
	logic [7:0] sh_q, tx_q, cmd_q;
	logic       start_tgl_q, start_ack_q, ara_q, lost_q, al_s1_q, al_s2_q;

	// Start condition: data falls while the clock is high
	always_ff @(negedge sda_in or negedge resetn)
		if (!resetn)
			start_tgl_q <= 1'b0;
		else if (smb_clk)
			start_tgl_q <= ~start_tgl_q;

	// Byte assembly and address decode
	wire       start_w = start_tgl_q != start_ack_q;
	wire [7:0] byte_w  = {sh_q[6:0], sda_in};
	wire       last_w  = cnt_q == 3'h7;
	wire       own_w   = byte_w[7:1] == own_addr;                        // [R8]
	wire       ara_w   = byte_w[7:1] == ARA_ADDR && byte_w[0] && al_s2_q && !own_w;

	// Protocol sequencing on rising clock edges
	always_ff @(posedge smb_clk or negedge resetn)
		if (!resetn)
		begin
			st_q <= LK_IDLE; nxt_q <= LK_IDLE; cnt_q <= 3'h0; sh_q <= 8'h00;
			tx_q <= 8'hFF; cmd_q <= CMD_LOC; start_ack_q <= 1'b0; ara_q <= 1'b0;
			lost_q <= 1'b0; al_s1_q <= 1'b0; al_s2_q <= 1'b0; evt_tgl <= 1'b0;
			evt <= '{kind: EV_CMD, cmd: CMD_LOC, data: 8'h00};
		end
		else
		begin
			al_s1_q <= alert_lvl;
			al_s2_q <= al_s1_q;
			sh_q <= byte_w;
			cnt_q <= cnt_q + 3'h1;
			if (start_w)
			begin
				start_ack_q <= start_tgl_q;
				st_q <= LK_ADDR;
				cnt_q <= 3'h1;
			end
			else
				unique case (st_q)
					LK_IDLE: cnt_q <= 3'h0;
					LK_ADDR: if (last_w)
					begin
						st_q <= (own_w || ara_w) ? LK_ACK : LK_IDLE;    // [R9] [R10]
						nxt_q <= byte_w[0] ? LK_TX : LK_CMD;
						ara_q <= ara_w;
						lost_q <= 1'b0;
						tx_q <= ara_w ? {own_addr, 1'b1} : rd_byte;      // [R22] [R12]
						cnt_q <= 3'h0;
					end
					LK_ACK: begin st_q <= nxt_q; cnt_q <= 3'h0; end
					LK_CMD: if (last_w)
					begin
						st_q <= LK_ACK; nxt_q <= LK_DATA; cmd_q <= byte_w;  // [R11]
						evt_tgl <= ~evt_tgl;
						evt <= '{kind: EV_CMD, cmd: byte_w, data: 8'h00};
					end
					LK_DATA: if (last_w)
					begin
						st_q <= LK_ACK; nxt_q <= LK_IDLE;                    // [R9]
						evt_tgl <= ~evt_tgl;
						evt <= '{kind: EV_WR, cmd: cmd_q, data: byte_w};
					end
					LK_TX:
					begin
						tx_q <= {tx_q[6:0], 1'b1};
						if (tx_q[7] && !sda_in)
							lost_q <= 1'b1;                                  // Lost arbitration
						if (last_w)
							st_q <= LK_TXACK;
					end
					LK_TXACK:
					begin
						st_q <= LK_IDLE;                                     // [R10] host nacks
						if (!lost_q)
						begin
							evt_tgl <= ~evt_tgl;
							evt <= '{kind: ara_q ? EV_ARA : EV_RD, cmd: cmd_q, data: 8'h00};
						end
					end
				endcase
		end

	// Pin drive changes on falling edges, while the clock is low
	always_ff @(negedge smb_clk or negedge resetn)
		if (!resetn)
		begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			sda_oe <= st_q == LK_ACK || (st_q == LK_TX && !lost_q && !tx_q[7]);
			sda_out <= 1'b0;
		end

	// Only the own or alert response address is acknowledged
	addr_ack_a: assert property (@(posedge smb_clk) disable iff (!resetn) // [R8]
		(st_q == LK_ADDR && last_w && !start_w) |=> (st_q == LK_ACK) == $past(own_w || ara_w))
		else $error("address acknowledge mismatch");
	// A data byte becomes a write event
	write_evt_a: assert property (@(posedge smb_clk) disable iff (!resetn) // [R9]
		(st_q == LK_DATA && last_w && !start_w) |=> evt_tgl != $past(evt_tgl) && evt.kind == EV_WR)
		else $error("write byte not handed to core");
	// Alert response returns the latched address with bit 0 set
	ara_byte_a: assert property (@(posedge smb_clk) disable iff (!resetn) // [R22]
		(st_q == LK_ADDR && last_w && !start_w && ara_w) |=> tx_q == {own_addr, 1'b1} && ara_q)
		else $error("alert response byte wrong");
endmodule : dts_smb_link

// *** rtl/dts_sensor.sv ***
// Dual-channel temperature readout with an SMBus slave register interface.
// Assumes a converter front end giving quarter-degree samples held stable.
//
// Overview of operation
// R1: Standby pin low or standby bit stops converter
// R2: Standby keeps registers and serial interface alive
// R3: Hardware standby ignores the one-shot command
// R4: Software standby one-shot runs a single conversion
// R5: Standby pin overrides every software conversion request
// R6: Standby mid-conversion aborts, temperatures stay unchanged
// R7: Each conversion lasts 125 ms
// R8: One slave address serves both channels
// R9: Write byte stores data in selected register
// R10: Read byte returns one byte, host nacks
// R11: Send byte carries only a command
// R12: Receive byte reads the last selected register
// R13: Temperatures are 8-bit twos complement degrees
// R14: Half-degree offset rounds readings to nearest
// R15: Four limits; reaching one raises the alert
// R16: High limits reset to plus 127
// R17: Low limits reset to minus 55
// R18: Open diode tested at every conversion start
// R19: No diode fault reported before first conversion
// R20: Remote short to return reads zero
// R21: Anode short to supply reads 127, alarms
// R22: Alert response returns latched address, bit 0 one
// R23: Standby control is configuration bit 6
// R24: One-shot is command 0Fh, send byte
// R25: Low alarm at or below, high at or above
// R26: Open diode sets fault flag and alert
module dts_sensor
	import dts_pkg::*;
#(
	parameter int CONV_MS_P = CONV_MS
)(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// SMBus pins
	input  wire logic       smb_clk,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Alert open-drain pin
	output logic            alert_out,
	output logic            alert_oe,
	// Standby and address straps
	input  wire logic       standby_pin_n,
	input  wire logic       addr_strap_a,
	input  wire logic       addr_strap_b,
	// Converter front end
	input  wire logic [9:0] local_raw_in,
	input  wire logic [9:0] remote_raw_in,
	input  wire logic       diode_anode_open_in,
	input  wire logic       diode_anode_gnd_in,
	input  wire logic       diode_anode_vcc_in
);
	localparam int CONV_CYC = CONV_MS_P * (CLK_HZ / 1000);               // [R7]
	localparam int CW       = $clog2(CONV_CYC);
	localparam int PW       = 26;

	typedef enum {CV_IDLE, CV_BUSY} dts_cv_e;

	// Quarter-degree sample to whole degrees, with a half-degree offset
	function automatic logic [7:0] dts_round(input logic [9:0] raw);
		logic signed [10:0] sum;
		sum = ($signed({raw[9], raw}) + 11'sh002) >>> 2;                // [R14]
		if (sum > $signed(11'(signed'(TEMP_MAX))))
			return TEMP_MAX;
		if (sum < $signed(11'(signed'(TEMP_MIN))))
			return TEMP_MIN;
		return sum[7:0];                                                 // [R13]
	endfunction : dts_round

	logic [PW-1:0] pin_s1_q, pin_s2_q;
	logic [2:0]    evt_sync_q;
	logic [2:0]    fill_q;
	logic [6:0]    own_addr_q;
	logic [7:0]    ptr_q, rd_byte_q, rate_q, loc_q, rem_q;
	logic [7:0]    lim_q [4];
	logic [1:0]    cfg_q;
	logic [4:0]    flags_q, cond_q;
	logic          alert_q, os_run_q, conv_seen_q;
	logic [CW-1:0] cnt_q;
	dts_cv_e       cv_st_q;
	logic          lk_evt_tgl;
	dts_evt_s      lk_evt;

	// Serial engine on the host's clock
	dts_smb_link u_link (
		.smb_clk   (smb_clk),
		.resetn    (resetn),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.own_addr  (own_addr_q),
		.rd_byte   (rd_byte_q),
		.alert_lvl (alert_q),
		.evt_tgl   (lk_evt_tgl),
		.evt       (lk_evt)
	);

	// Standby, diode, strap and converter pins pass two flops; the SMBus pins go straight to the link
	wire [PW-1:0] pin_w = {standby_pin_n, diode_anode_open_in, diode_anode_gnd_in,
		diode_anode_vcc_in, addr_strap_b, addr_strap_a, local_raw_in, remote_raw_in};
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
		end
		else
		begin
			pin_s1_q <= pin_w;
			pin_s2_q <= pin_s1_q;
		end

	// Synchronised pin names
	wire       hw_standby_pin_n = !pin_s2_q[25];                                  // [R1]
	wire       open_s  = pin_s2_q[24];
	wire       gnd_s   = pin_s2_q[23];
	wire       vcc_s   = pin_s2_q[22];
	wire [1:0] strap_s = pin_s2_q[21:20];
	wire [9:0] loc_raw = pin_s2_q[19:10];
	wire [9:0] rem_raw = pin_s2_q[9:0];

	// Straps are caught once the synchroniser has filled after reset
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			fill_q <= 3'h0;
			own_addr_q <= SLAVE_BASE;
		end
		else
		begin
			fill_q <= {fill_q[1:0], 1'b1};
			if (!fill_q[2])
				own_addr_q <= {SLAVE_BASE[6:2], strap_s};
		end

	// Event toggle from the link; payload is stable when the toggle lands
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			evt_sync_q <= 3'h0;
		else
			evt_sync_q <= {evt_sync_q[1:0], lk_evt_tgl};

	// Event decode
	wire evt_new_w = evt_sync_q[2] != evt_sync_q[1];
	wire ev_cmd_w  = evt_new_w && lk_evt.kind == EV_CMD;
	wire ev_wr_w   = evt_new_w && lk_evt.kind == EV_WR;
	wire ev_rd_w   = evt_new_w && lk_evt.kind == EV_RD;
	wire ev_ara_w  = evt_new_w && lk_evt.kind == EV_ARA;
	wire os_cmd_w  = ev_cmd_w && lk_evt.cmd == CMD_ONESHOT;             // [R24] [R11]
	wire cfg_wr_w  = ev_wr_w && lk_evt.cmd == CMD_WCFG;                 // [R9]
	wire rate_wr_w = ev_wr_w && lk_evt.cmd == CMD_WRATE;
	wire st_rd_w   = ev_rd_w && ptr_q == CMD_STATUS;

	// Command pointer selects what a later read returns
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			ptr_q <= CMD_LOC;
		else if (ev_cmd_w)
			ptr_q <= lk_evt.cmd;                                         // [R12]

	// Configuration and rate registers stay writable in standby
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			cfg_q <= CFG_POR;
			rate_q <= RATE_POR;
		end
		else
		begin
			if (cfg_wr_w)
				cfg_q <= lk_evt.data[7:6];                               // [R23] [R2]
			if (rate_wr_w)
				rate_q <= lk_evt.data;
		end

	// One writable limit per channel and direction
	for (genvar i = 0; i < 4; i++)
	begin : g_lim
		logic hit_w;
		assign hit_w = ev_wr_w && lk_evt.cmd == CMD_WLIM + 8'(i);
		always_ff @(posedge core_clk or negedge resetn)
			if (!resetn)
				lim_q[i] <= (i % 2 == 0) ? HIGH_POR : LOW_POR;           // [R16] [R17]
			else if (hit_w)
				lim_q[i] <= lk_evt.data;                                 // [R15]
	end

	// Conversion control
	wire sw_standby_pin_n = cfg_q[CFG_STANDBY_PIN_N];                                      // [R23]
	wire mask_w  = cfg_q[CFG_MASK];
	wire busy_w  = cv_st_q == CV_BUSY;
	// No start until the pin synchroniser has filled, so reset fill values cannot start one
	wire start_w = fill_q[2] && !busy_w && !hw_standby_pin_n && (!sw_standby_pin_n || os_cmd_w); // [R3] [R4] [R5] [R19]
	wire abort_w = busy_w && (hw_standby_pin_n || (sw_standby_pin_n && !os_run_q));        // [R6]
	wire done_w  = busy_w && !abort_w && cnt_q == CW'(CONV_CYC - 1);     // [R7]

	// Conversion sequencer; a one-shot while busy is ignored
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			cv_st_q <= CV_IDLE;
			cnt_q <= '0;
			os_run_q <= 1'b0;
		end
		else
			unique case (cv_st_q)
				CV_IDLE: if (start_w)
				begin
					cv_st_q <= CV_BUSY;
					cnt_q <= '0;
					os_run_q <= sw_standby_pin_n;                                 // [R4]
				end
				CV_BUSY: if (abort_w || done_w)
					cv_st_q <= CV_IDLE;                                  // [R1]
				else
					cnt_q <= cnt_q + CW'(1);
			endcase

	// Results, including the diode fault substitutes
	wire [7:0] loc_rnd_w  = dts_round(loc_raw);
	wire [7:0] loc_next_w = vcc_s ? TEMP_MAX : loc_rnd_w;                // [R21]
	wire [7:0] rem_next_w = vcc_s ? TEMP_MAX : gnd_s ? TEMP_ZERO : dts_round(rem_raw); // [R20]

	// Limit comparisons, inclusive at both ends
	wire lh_w = $signed(loc_next_w) >= $signed(lim_q[0]);                // [R25]
	wire ll_w = $signed(loc_next_w) <= $signed(lim_q[1]);                // [R25]
	wire rh_w = $signed(rem_next_w) >= $signed(lim_q[2]);                // [R25]
	wire rl_w = $signed(rem_next_w) <= $signed(lim_q[3]);                // [R25]

	// New flag events: limits at the end, open diode at the start
	wire [4:0] lim_set_w = done_w ? {lh_w, ll_w, rh_w, rl_w, 1'b0} : 5'h00;
	wire [4:0] set_w     = lim_set_w | ((start_w && open_s) ? 5'h01 : 5'h00); // [R18]

	// Temperature registers update only on a completed conversion
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			loc_q <= TEMP_POR;
			rem_q <= TEMP_POR;
		end
		else if (done_w)
		begin
			loc_q <= loc_next_w;                                         // [R6] [R13]
			rem_q <= rem_next_w;
		end

	// Conditions seen by the last test; a status read keeps persisting ones
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			cond_q <= 5'h00;
			conv_seen_q <= 1'b0;
		end
		else
		begin
			if (done_w)
				cond_q[4:1] <= lim_set_w[4:1];
			if (start_w)
			begin
				cond_q[FL_OPEN] <= open_s;                               // [R18]
				conv_seen_q <= 1'b1;
			end
		end

	// Sticky flags and alert latch; a new event wins over a clear
	wire [4:0] flags_d = (st_rd_w ? cond_q : flags_q) | set_w;           // [R26]
	wire       alert_d = (alert_q && !ev_ara_w) || (|set_w && !mask_w);  // [R15] [R26]
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			flags_q <= 5'h00;                                            // [R19]
			alert_q <= 1'b0;
			alert_oe <= 1'b0;
			alert_out <= 1'b0;
		end
		else
		begin
			flags_q <= flags_d;
			alert_q <= alert_d;
			alert_oe <= alert_d;
			alert_out <= 1'b0;
		end

	// Read data selected by the command pointer
	wire [7:0] lim_off_w = ptr_q - CMD_RLIM;
	wire       is_lim_w  = ptr_q >= CMD_RLIM && ptr_q <= CMD_RLIM_LT;
	wire [7:0] status_w  = {busy_w, flags_q, 2'b00};
	wire [7:0] rd_byte_w = ptr_q == CMD_LOC    ? loc_q :
		ptr_q == CMD_REM    ? rem_q :
		ptr_q == CMD_STATUS ? status_w :
		ptr_q == CMD_RCFG   ? {cfg_q, 6'h00} :
		ptr_q == CMD_RRATE  ? rate_q :
		is_lim_w            ? lim_q[lim_off_w[1:0]] : 8'h00;

	// Held for the link, which samples it at the address acknowledge
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			rd_byte_q <= TEMP_POR;
		else
			rd_byte_q <= rd_byte_w;                                      // [R10] [R12]

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Standby pin holds the converter off
	standby_pin_n_pin_a: assert property (hw_standby_pin_n |=> !busy_w) // [R1] [R5]
		else $error("converter running in hardware standby");
	// Standby bit without a one-shot keeps it off
	standby_pin_n_bit_a: assert property ((!busy_w && sw_standby_pin_n && !os_cmd_w) |=> !busy_w) // [R1] [R23]
		else $error("converter started in software standby");
	// One-shot is refused under the standby pin
	hw_oneshot_a: assert property ((hw_standby_pin_n && os_cmd_w) |=> !busy_w ##1 !busy_w) // [R3]
		else $error("one-shot started in hardware standby");
	// One-shot runs under the standby bit
	sw_oneshot_a: assert property ((!busy_w && sw_standby_pin_n && !hw_standby_pin_n && os_cmd_w) |=> busy_w && os_run_q) // [R4]
		else $error("one-shot ignored in software standby");
	// Aborted conversion leaves both readings alone
	abort_keep_a: assert property (abort_w |=> $stable(loc_q) && $stable(rem_q) && !busy_w) // [R6]
		else $error("aborted conversion changed a reading");
	// A conversion ends only after the full period or on an abort
	conv_len_a: assert property ($fell(busy_w) |-> $past(abort_w) || $past(cnt_q) == CW'(CONV_CYC - 1)) // [R7]
		else $error("conversion period wrong");
	// Local reading is the rounded sample
	round_val_a: assert property ((done_w && !vcc_s) |=> loc_q == $past(loc_rnd_w)) // [R13] [R14]
		else $error("local reading not rounded sample");
	// Reaching the high limit flags and alerts
	high_alarm_a: assert property ((done_w && $signed(loc_next_w) >= $signed(lim_q[0])) // [R15] [R25]
		|=> flags_q[FL_LHIGH] && (alert_q || mask_w))
		else $error("high limit reached without alarm");
	// Open diode test at the start
	open_flag_a: assert property ((start_w && open_s) |=> flags_q[FL_OPEN] && (alert_q || mask_w)) // [R18] [R26]
		else $error("open diode not flagged");
	// No fault reported before the first conversion
	por_fault_a: assert property (!conv_seen_q |-> !flags_q[FL_OPEN]) // [R19]
		else $error("diode fault before any conversion");
	// Shorted remote input reads zero
	short_gnd_a: assert property ((done_w && gnd_s && !vcc_s) |=> rem_q == TEMP_ZERO) // [R20]
		else $error("shorted remote did not read zero");
	// Anode at supply reads full scale on both channels
	short_vcc_a: assert property ((done_w && vcc_s) |=> loc_q == TEMP_MAX && rem_q == TEMP_MAX) // [R21]
		else $error("anode short did not read full scale");

	// Main scenarios
	oneshot_c: cover property (sw_standby_pin_n && os_cmd_w ##1 busy_w);
	abort_c: cover property (busy_w && hw_standby_pin_n ##1 !busy_w);
	ara_clear_c: cover property (alert_q && ev_ara_w ##1 !alert_q);
endmodule : dts_sensor

// *** test/dts_host_model.sv ***
// SMBus host master model: owns the serial clock and pulls the data line low.
// Assumes the bench resolves the open-drain data line with a pull-up.
module dts_host_model
	import dts_pkg::*;
(
	// Serial clock and data
	output logic      smb_clk,
	output logic      sda_pull,
	input  wire logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int Q = 16;                                              // Serial clock period 4*Q = 64 ns
	// Bus idles with clock high and data released
	initial
	begin
		smb_clk = 1'b1;
		sda_pull = 1'b0;
	end
	// Start or repeated start; the clock is left low
	task automatic start_c();
		sda_pull = 1'b0;
		#Q smb_clk = 1'b1;
		#(2*Q) sda_pull = 1'b1;
		#(2*Q) smb_clk = 1'b0;
	endtask : start_c
	// Stop; the clock then stands high until the next frame
	task automatic stop_c();
		#Q sda_pull = 1'b1;
		#Q smb_clk = 1'b1;
		#(2*Q) sda_pull = 1'b0;
		#(2*Q);
	endtask : stop_c
	// One bit: data set while low, sampled on the rise
	task automatic bit_c(input logic b, output logic r);
		#Q sda_pull = ~b;
		#Q smb_clk = 1'b1;
		r = sda_in;
		#(2*Q) smb_clk = 1'b0;
	endtask : bit_c
	// Byte out MSB first, then the slave acknowledge
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_c(v[i], r);
		bit_c(1'b1, r);
		ack = ~r;
	endtask : put
	// Byte in MSB first, then a host not-acknowledge
	task automatic get(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_c(1'b1, r);
			v[i] = r;
		end
		bit_c(1'b1, r);
	endtask : get
	// Write byte, or send byte when no data goes with the command
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic has_d,
		output logic ack);
		logic k0, k1, k2;
		k2 = 1'b1;
		start_c();
		put({a, 1'b0}, k0);
		put(c, k1);
		if (has_d)
			put(d, k2);
		stop_c();
		ack = k0 & k1 & k2;
	endtask : wr
	// Read byte, or receive byte when no command is sent
	task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic has_c, output logic [7:0] d,
		output logic ack);
		logic k0, k1, k2;
		k0 = 1'b1;
		k1 = 1'b1;
		d = 8'h00;
		if (has_c)
		begin
			start_c();
			put({a, 1'b0}, k0);
			put(c, k1);
		end
		start_c();
		put({a, 1'b1}, k2);
		if (k2)
			get(d);
		stop_c();
		ack = k0 & k1 & k2;
	endtask : rd
endmodule : dts_host_model

// *** test/testbench.sv ***
// Self-checking bench for the dual temperature sensor readout.
// Assumes the host model owns the bus and the conversion lasts 1 ms.
module testbench
	import dts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         CONV_CYC = CLK_HZ / 1000;
	localparam logic [6:0] DEV      = {SLAVE_BASE[6:2], 2'b01};
	logic       core_clk = 1'b0;
	logic       resetn   = 1'b0;
	logic       standby_pin_n_n   = 1'b0;
	logic [9:0] loc_raw  = 10'h18E;
	logic [9:0] rem_raw  = 10'h000;
	logic       d_open   = 1'b1;
	logic       d_gnd    = 1'b1;
	logic       d_vcc    = 1'b0;
	logic       smb_clk, sda_pull, sda_out, sda_oe, alert_out, alert_oe;
	int         n_errors = 0;
	int         checked  = 0;
	// Open-drain data line with pull-up
	wire sda_w = ~((sda_oe & ~sda_out) | sda_pull);
	always #12.5 core_clk = ~core_clk;
	dts_sensor #(.CONV_MS_P(1)) DUT (.core_clk(core_clk), .resetn(resetn), .smb_clk(smb_clk),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
		.standby_pin_n(standby_pin_n_n), .addr_strap_a(1'b1), .addr_strap_b(1'b0), .local_raw_in(loc_raw),
		.remote_raw_in(rem_raw), .diode_anode_open_in(d_open), .diode_anode_gnd_in(d_gnd),
		.diode_anode_vcc_in(d_vcc));
	dts_host_model host (.smb_clk(smb_clk), .sda_pull(sda_pull), .sda_in(sda_w));
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Register access at the device address, acknowledge checked
	task automatic reg_rd(input logic [7:0] c, output logic [7:0] d);
		logic ack;
		host.rd(DEV, c, 1'b1, d, ack);
		chk({7'h00, ack}, 8'h01);
	endtask : reg_rd
	task automatic reg_wr(input logic [7:0] c, input logic [7:0] d, input logic has_d);
		logic ack;
		host.wr(DEV, c, d, has_d, ack);
		chk({7'h00, ack}, 8'h01);
	endtask : reg_wr
	// Values after reset, diode open but never checked yet
	task automatic t_por();
		logic [7:0] d;
		for (logic [7:0] c = 8'h05; c <= 8'h08; c++)
		begin
			reg_rd(c, d);
			chk(d, c[0] ? 8'h7F : 8'hC9);
		end
		reg_rd(8'h02, d);
		chk(d, 8'h00);
	endtask : t_por
	// Pin standby: one-shot ignored, registers still served
	task automatic t_hw_standby();
		logic [7:0] d;
		logic       ack;
		reg_wr(8'h0F, 8'h00, 1'b0);
		reg_rd(8'h02, d);
		chk(d, 8'h00);
		reg_wr(8'h0B, 8'h64, 1'b1);
		reg_rd(8'h05, d);
		chk(d, 8'h64);
		host.rd(DEV, 8'h00, 1'b0, d, ack);
		chk(d, 8'h64);
	endtask : t_hw_standby
	// Standby bit set, one-shot runs exactly one conversion
	task automatic t_oneshot();
		logic [7:0] d;
		reg_wr(8'h09, 8'h40, 1'b1);
		@(negedge core_clk);
		standby_pin_n_n = 1'b1;
		repeat (100) @(posedge core_clk);
		reg_rd(8'h02, d);
		chk(d, 8'h00);
		reg_wr(8'h0F, 8'h00, 1'b0);
		reg_rd(8'h02, d);
		chk(d, 8'h84);
		repeat (CONV_CYC - 3000) @(posedge core_clk);
		reg_rd(8'h02, d);
		chk({7'h00, d[7]}, 8'h01);
		repeat (3000) @(posedge core_clk);
		reg_rd(8'h00, d);
		chk(d, 8'((398 + 2) / 4));
		reg_rd(8'h01, d);
		chk(d, 8'h00);
		reg_rd(8'h02, d);
		chk(d, 8'h44);
		chk({7'h00, alert_oe}, 8'h01);
	endtask : t_oneshot
	// Alert response returns the strapped address and clears the alert
	task automatic t_ara();
		logic [7:0] d;
		logic       ack;
		host.rd(7'h0C, 8'h00, 1'b0, d, ack);
		chk(d, {DEV, 1'b1});
		repeat (10) @(posedge core_clk);
		chk({7'h00, alert_oe}, 8'h00);
		chk({7'h00, alert_out}, 8'h00);
	endtask : t_ara
	// Pin standby in mid-conversion drops the results
	task automatic t_abort();
		logic [7:0] d;
		@(negedge core_clk);
		loc_raw = 10'h0C8;
		d_vcc = 1'b1;
		reg_wr(8'h0F, 8'h00, 1'b0);
		reg_rd(8'h02, d);
		chk({7'h00, d[7]}, 8'h01);
		@(negedge core_clk);
		standby_pin_n_n = 1'b0;
		repeat (CONV_CYC) @(posedge core_clk);
		reg_rd(8'h02, d);
		chk({7'h00, d[7]}, 8'h00);
		reg_rd(8'h00, d);
		chk(d, 8'h64);
		reg_rd(8'h01, d);
		chk(d, 8'h00);
	endtask : t_abort
	// Verdict and end of run
	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// Watchdog against a hung bus or wait
	initial
	begin
		#2_300_000;
		n_errors++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		repeat (40) @(posedge core_clk);
		t_por();
		t_hw_standby();
		t_oneshot();
		t_ara();
		t_abort();
		report_and_stop();
	end
endmodule : testbench
